/* design/pin_ctrl_pkg.sv */
// package: register map, field positions and shared types for the pin controller
package pin_ctrl_pkg;
  localparam logic [5:0] SERIAL_PIN_SELECT_OFS = 6'h04;
  localparam logic [5:0] SERIAL_CLOCK_CONFIG_OFS = 6'h05;
  localparam logic [5:0] MISC_PIN_CONFIG_OFS = 6'h0c;
  localparam logic [5:0] COMPARATOR_PIN_ENABLE_OFS = 6'h18;
  localparam logic [5:0] INTERRUPT_PIN_SELECT_OFS = 6'h24;
  localparam logic [5:0] EVENT_PIN_SELECT_OFS = 6'h25;
  localparam logic [5:0] DPORT_LOW_DRIVE_OFS = 6'h2c;
  localparam logic [5:0] RPORT_GROUP0_DRIVE_OFS = 6'h30;
  localparam logic [5:0] RPORT_GROUP4_DRIVE_OFS = 6'h34;
  localparam logic [5:0] RPORT_GROUP6_DRIVE_OFS = 6'h36;
  localparam logic [5:0] RPORT_GROUPA_DRIVE_OFS = 6'h3a;
  localparam logic [5:0] TIMER_C_MODE2_OFS = 6'h14;
  localparam logic [5:0] TIMER_D_MODE2_OFS = 6'h15;
  localparam logic [3:0] REG_RESET = 4'h0;
  localparam logic [43:0] PIN_RESET = 44'h0;
  // field positions
  localparam int GLOBAL_PULL_BIT = 3;
  localparam int OPEN_DRAIN_BIT = 2;
  localparam int SERIAL_IN_SEL_BIT = 1;
  localparam int SERIAL_OUT_SEL_BIT = 0;
  localparam int SERIAL_CLK_PIN_BIT = 3;
  localparam int EVENT_INPUT_BIT = 1;
  // rport pin index: group g bit b at 4*slot+b; slots 0..4 groups 0..4, 5..8 groups 6..9, 9 group a
  localparam int RPORT_PINS = 38;
  localparam int DPORT_PINS = 9;
  localparam int R3_1 = 13;
  localparam int R3_2 = 14;
  localparam int R4_0 = 16;
  localparam int R4_1 = 17;
  localparam int R4_2 = 18;
  localparam int R4_3 = 19;
  // timer mode values; 3'h0 means port use, arbitrary width of the timer D field
  localparam logic [2:0] TIMER_PORT_MODE = 3'h0;
  localparam logic [3:0] TIMER_D_PORT_MODE = 4'h0;

  // register write strobe from the core
  typedef struct packed {
    logic we;
    logic [5:0] addr;
    logic [3:0] data;
  } reg_write_t;

  // per-pin pad controls
  typedef struct packed {
    logic [DPORT_PINS-1:0] dOe;
    logic [DPORT_PINS-1:0] dOut;
    logic [DPORT_PINS-1:0] dPull;
    logic [RPORT_PINS-1:0] rOe;
    logic [RPORT_PINS-1:0] rOut;
    logic [RPORT_PINS-1:0] rPull;
    logic r43PmosOff;
  } pad_ctrl_t;

  // per-pin function routing
  typedef struct packed {
    logic [3:0] irqEnable;
    logic eventEnable;
    logic timerCEnable;
    logic timerDEnable;
    logic serialClockEnable;
    logic serialInEnable;
    logic serialOutEnable;
    logic [1:0] comparatorEnable;
    logic [2:0] serialClockSource;
  } func_sel_t;
endpackage : pin_ctrl_pkg

/* design/port_pin_buffer_and_function_control.sv */
// design: pin buffer, pull and shared-function control for the d and r ports
// How it works
// - dport buffer control bits enable D pins
// - one rport buffer control register per group
// - rport latch written four bits, pin levels read back
// - buffer controls decoded in data RAM area
// - interrupt_pin_select routes R0 to irq inputs
// - bit 1 selects irq, 0 port; resets zero
// - event_pin_select bit 1 routes R4_0 event
// - timer output modes hand R3_1, R3_2 over
// - serial pins R4_1..R4_3 under mode bits
// - serial_pin_select bits route SI, SO; reset zero
// - serial clock pin select and clock source code
// - open_drain_select makes R4_3 NMOS open drain
// - comparator_pin_enable connects RD0, RD1 to comparator
// - global pull enable gates per-pin latch pulls
// - D0..D3 pull down, others pull up
// - pulls independent of peripheral function use
// - misc register four bits reset zero
// - reset and stop clear buffers and functions
// - pull-up pins: drive and pull truth table
// - pull-down pins: pull when latch zero
// - peripheral function takes precedence over port
`timescale 1ns/1ps
`default_nettype none

module port_pin_buffer_and_function_control (
  input wire logic clk,
  input wire logic rst,
  input wire logic stopMode,
  input wire pin_ctrl_pkg::reg_write_t regWrite,
  input wire logic rportWrite,
  input wire logic [3:0] rportSlot,
  input wire logic [3:0] rportData,
  input wire logic rportRead,
  input wire logic [39:0] rportPinIn,
  input wire logic [8:0] dportLatchIn,
  input wire logic timerCOut,
  input wire logic timerCOutEn,
  input wire logic timerDOut,
  input wire logic timerDOutEn,
  input wire logic serialClockOut,
  input wire logic serialClockOutEn,
  input wire logic serialOutData,
  output var pin_ctrl_pkg::pad_ctrl_t padCtrl,
  output var pin_ctrl_pkg::func_sel_t funcSel,
  output logic [3:0] rportReadData
);
  typedef struct packed {
    logic [2:0][3:0] dDrive;
    logic [9:0][3:0] rDrive;
    logic [9:0][3:0] rLatch;
    logic [3:0] misc;
    logic [1:0] serialSel;
    logic [3:0] serialClk;
    logic [3:0] irqSel;
    logic eventSel;
    logic [1:0] cmpSel;
    logic [2:0] timerCMode;
    logic [3:0] timerDMode;
    logic [3:0] readData;
    pin_ctrl_pkg::pad_ctrl_t pad;
    pin_ctrl_pkg::func_sel_t func;
  } state_t;

  state_t s_q;
  state_t s_d;
  logic [8:0] dDriveFlat;
  logic [37:0] rDriveFlat;
  logic [37:0] rLatchFlat;
  logic [5:0] a;
  logic pullOn;

  // overview of the pin plan
  // every control register here is write only; software keeps its own copy
  // the port output latch of the d pins lives outside, so its value comes in
  // the r port latch lives here, one four-bit group per slot
  // slots 0..4 hold groups 0..4, slots 5..8 hold groups 6..9, slot 9 group a
  // group a only has two pins, so its upper latch and drive bits go nowhere
  // the d drive registers sit at three consecutive addresses
  // the low one covers four pins, the middle two, the high one three
  // the high register leaves its bit 0 unused, so pins start at bit 1
  // the r drive registers sit in two runs with a hole where group 5 would be
  // a write to the hole is dropped rather than aliased onto a neighbour
  //
  // pad resolution
  // oe high means the cmos stage drives the pin from the out value
  // oe low leaves the pin at high impedance, apart from the pull transistor
  // the pull transistor follows the latch while the global pull bit is set
  // d0..d3 pull down, so their pull is on when the latch holds zero
  // every other pin pulls up, so its pull is on when the latch holds one
  // pulls do not look at function routing at all; a pin used by a peripheral
  // still gets its pull from its own latch, which software must keep in mind
  //
  // peripheral routing
  // a routed function always wins over port use on its pin
  // input functions (irq, event count, serial in) switch the driver off
  // output functions take over both oe and the out value of their pin
  // serial out always drives while routed; open drain only gates the pmos
  // the timer outputs and the serial clock supply their own direction
  // the comparator inputs sit on input-only pins, so only routing is reported
  //
  // timing
  // a control write lands in the state at the first edge after it is taken
  // the pad and routing outputs follow one edge later, both from flip-flops
  // this costs a cycle of latency but keeps every output glitch free
  // pin reads capture the group's levels in the request cycle and show them in the cycle after
  //
  // reset and stop
  // either one clears the whole state, so every pin floats with no pull
  // writes made while either one is active are lost on purpose
  // the timer mode copies are cleared too, handing pins back to port use
  //
  // known limits
  // an unknown address is ignored without any error indication
  // a slot above nine is ignored for writes and reads alike
  // a read and a write on one slot in one cycle both take effect
  // the read returns pin levels, not the latch, as the pins really show
  // a driven pin therefore reads back its own latch through the pad
  // a floating pin with no pull reads whatever the board leaves there

  // flatten grouped registers into pin order (group a keeps two bits)
  assign dDriveFlat = {s_q.dDrive[2][3:1], s_q.dDrive[1][1:0], s_q.dDrive[0]};
  assign rDriveFlat = {s_q.rDrive[9][1:0], s_q.rDrive[8:0]};
  assign rLatchFlat = {s_q.rLatch[9][1:0], s_q.rLatch[8:0]};
  assign a = regWrite.addr;
  assign pullOn = s_q.misc[pin_ctrl_pkg::GLOBAL_PULL_BIT];

  // next state: register writes, latch writes, then pad resolution from current state
  always_comb begin
    s_d = s_q;
    if (regWrite.we) begin
      // buffer controls sit in the RAM area, reached by plain data writes
      if (a >= pin_ctrl_pkg::DPORT_LOW_DRIVE_OFS && a < pin_ctrl_pkg::RPORT_GROUP0_DRIVE_OFS
          && a != 6'h2f) begin
        s_d.dDrive[2'(a - pin_ctrl_pkg::DPORT_LOW_DRIVE_OFS)] = regWrite.data;
      end
      if (a >= pin_ctrl_pkg::RPORT_GROUP0_DRIVE_OFS && a <= pin_ctrl_pkg::RPORT_GROUP4_DRIVE_OFS) begin
        s_d.rDrive[4'(a - pin_ctrl_pkg::RPORT_GROUP0_DRIVE_OFS)] = regWrite.data;
      end
      // 0x35 is a hole in the map: group 5 does not exist
      if (a >= pin_ctrl_pkg::RPORT_GROUP6_DRIVE_OFS && a <= pin_ctrl_pkg::RPORT_GROUPA_DRIVE_OFS) begin
        s_d.rDrive[4'(a - pin_ctrl_pkg::RPORT_GROUP6_DRIVE_OFS + 6'h05)] = regWrite.data;
      end
      unique case (a)
        pin_ctrl_pkg::MISC_PIN_CONFIG_OFS: s_d.misc = regWrite.data;
        pin_ctrl_pkg::SERIAL_PIN_SELECT_OFS: s_d.serialSel = regWrite.data[1:0];
        pin_ctrl_pkg::SERIAL_CLOCK_CONFIG_OFS: s_d.serialClk = regWrite.data;
        pin_ctrl_pkg::INTERRUPT_PIN_SELECT_OFS: s_d.irqSel = regWrite.data;
        pin_ctrl_pkg::EVENT_PIN_SELECT_OFS: s_d.eventSel = regWrite.data[1];
        pin_ctrl_pkg::COMPARATOR_PIN_ENABLE_OFS: s_d.cmpSel = regWrite.data[1:0];
        pin_ctrl_pkg::TIMER_C_MODE2_OFS: s_d.timerCMode = regWrite.data[2:0];
        pin_ctrl_pkg::TIMER_D_MODE2_OFS: s_d.timerDMode = regWrite.data;
        default: ;
      endcase
    end
    // four-bit port output latch and pin read
    if (rportWrite && rportSlot <= 4'h9) begin
      s_d.rLatch[rportSlot] = rportData;
    end
    if (rportRead && rportSlot <= 4'h9) begin
      s_d.readData = rportPinIn[{rportSlot, 2'b00} +: 4];
    end

    // function selections
    s_d.func.irqEnable = s_q.irqSel;
    s_d.func.eventEnable = s_q.eventSel;
    s_d.func.timerCEnable = s_q.timerCMode != pin_ctrl_pkg::TIMER_PORT_MODE;
    s_d.func.timerDEnable = s_q.timerDMode != pin_ctrl_pkg::TIMER_D_PORT_MODE;
    s_d.func.serialClockEnable = s_q.serialClk[pin_ctrl_pkg::SERIAL_CLK_PIN_BIT];
    s_d.func.serialInEnable = s_q.serialSel[pin_ctrl_pkg::SERIAL_IN_SEL_BIT];
    s_d.func.serialOutEnable = s_q.serialSel[pin_ctrl_pkg::SERIAL_OUT_SEL_BIT];
    s_d.func.serialClockSource = s_q.serialClk[2:0];
    s_d.func.comparatorEnable = s_q.cmpSel;

    // port use: buffer bit drives the latch value; pulls follow latch when globally on
    s_d.pad.dOe = dDriveFlat;
    s_d.pad.dOut = dportLatchIn;
    s_d.pad.dPull[3:0] = pullOn ? ~dportLatchIn[3:0] : 4'h0;
    s_d.pad.dPull[8:4] = pullOn ? dportLatchIn[8:4] : 5'h00;
    s_d.pad.rOe = rDriveFlat;
    s_d.pad.rOut = rLatchFlat;
    // pull setting ignores function routing on purpose
    s_d.pad.rPull = pullOn ? rLatchFlat : 38'h0;

    // peripheral overrides; input functions release the driver
    s_d.pad.rOe[3:0] = rDriveFlat[3:0] & ~s_q.irqSel;
    if (s_q.eventSel) s_d.pad.rOe[pin_ctrl_pkg::R4_0] = 1'b0;
    if (s_d.func.timerCEnable) begin
      s_d.pad.rOe[pin_ctrl_pkg::R3_1] = timerCOutEn;
      s_d.pad.rOut[pin_ctrl_pkg::R3_1] = timerCOut;
    end
    if (s_d.func.timerDEnable) begin
      s_d.pad.rOe[pin_ctrl_pkg::R3_2] = timerDOutEn;
      s_d.pad.rOut[pin_ctrl_pkg::R3_2] = timerDOut;
    end
    if (s_d.func.serialClockEnable) begin
      s_d.pad.rOe[pin_ctrl_pkg::R4_1] = serialClockOutEn;
      s_d.pad.rOut[pin_ctrl_pkg::R4_1] = serialClockOut;
    end
    if (s_d.func.serialInEnable) s_d.pad.rOe[pin_ctrl_pkg::R4_2] = 1'b0;
    if (s_d.func.serialOutEnable) begin
      s_d.pad.rOe[pin_ctrl_pkg::R4_3] = 1'b1;
      s_d.pad.rOut[pin_ctrl_pkg::R4_3] = serialOutData;
    end
    // open drain keeps the pmos off on R4_3 whether port or serial out
    s_d.pad.r43PmosOff = s_q.misc[pin_ctrl_pkg::OPEN_DRAIN_BIT];

    // reset and stop clear every control, leaving pins high impedance
    if (rst || stopMode) begin
      s_d = '0;
    end
  end

  // single state register; resolution is one cycle behind the controls
  always_ff @(posedge clk) begin
    s_q <= s_d;
  end

  assign padCtrl = s_q.pad;
  assign funcSel = s_q.func;
  assign rportReadData = s_q.readData;

  // checks
  sequence pullSet_s;
    pullOn && rLatchFlat[0];
  endsequence
  pull_up_a: assert property (@(posedge clk) disable iff (rst)
    pullSet_s and !stopMode |=> padCtrl.rPull[0]) else $error("pull-up not on");
  pull_down_a: assert property (@(posedge clk) disable iff (rst)
    pullOn && !dportLatchIn[0] && !stopMode |=> padCtrl.dPull[0]) else $error("pull-down not on");
  stop_clear_a: assert property (@(posedge clk)
    stopMode |=> padCtrl.rOe == 38'h0 && padCtrl.dOe == 9'h0 && funcSel == '0)
    else $error("stop did not clear pins");
  irq_route_a: assert property (@(posedge clk) disable iff (rst)
    funcSel.irqEnable[0] |-> !padCtrl.rOe[0]) else $error("irq pin still driven");
  open_drain_a: assert property (@(posedge clk) disable iff (rst)
    regWrite.we && a == pin_ctrl_pkg::MISC_PIN_CONFIG_OFS && regWrite.data[2] && !stopMode
    |-> ##2 padCtrl.r43PmosOff) else $error("open drain not applied");
  dport_drive_a: assert property (@(posedge clk) disable iff (rst)
    regWrite.we && a == pin_ctrl_pkg::DPORT_LOW_DRIVE_OFS && !stopMode
    |-> ##2 padCtrl.dOe[3:0] == $past(regWrite.data, 2)) else $error("dport drive lost");
  serial_out_a: assert property (@(posedge clk) disable iff (rst)
    funcSel.serialOutEnable |-> padCtrl.rOe[pin_ctrl_pkg::R4_3]) else $error("so not driven");
  latch_read_a: assert property (@(posedge clk) disable iff (rst)
    rportRead && rportSlot == 4'h0 && !stopMode |=> rportReadData == $past(rportPinIn[3:0]))
    else $error("port read wrong");
  pull_independent_a: assert property (@(posedge clk) disable iff (rst)
    funcSel.eventEnable && pullOn && rLatchFlat[16] && !stopMode |=> padCtrl.rPull[16])
    else $error("pull blocked by function");

  // d drive bits reach the pad enables one cycle later
  dport_oe_a: assert property (@(posedge clk) disable iff (rst)
    !stopMode |=> padCtrl.dOe == $past(dDriveFlat))
    else $error("dport enable mismatch");
  // pins with no shared function follow their drive bits
  rport_oe_low_a: assert property (@(posedge clk) disable iff (rst)
    !stopMode |=> padCtrl.rOe[12:4] == $past(rDriveFlat[12:4]))
    else $error("rport enable mismatch");
  // upper groups have no shared function at all
  rport_oe_high_a: assert property (@(posedge clk) disable iff (rst)
    !stopMode |=> padCtrl.rOe[37:20] == $past(rDriveFlat[37:20]))
    else $error("rport upper enable mismatch");
  // upper groups drive their latch values
  rport_out_a: assert property (@(posedge clk) disable iff (rst)
    !stopMode |=> padCtrl.rOut[37:20] == $past(rLatchFlat[37:20]))
    else $error("rport out mismatch");
  // a latch write lands in its slot
  latch_write_a: assert property (@(posedge clk) disable iff (rst)
    rportWrite && rportSlot == 4'h2 && !stopMode |=> s_q.rLatch[2] == $past(rportData))
    else $error("latch write lost");
  // slots above nine leave every latch alone
  slot_refuse_a: assert property (@(posedge clk) disable iff (rst)
    rportWrite && rportSlot > 4'h9 && !stopMode |=> s_q.rLatch == $past(s_q.rLatch))
    else $error("bad slot written");
  // buffer controls decode as plain data writes
  ram_decode_a: assert property (@(posedge clk) disable iff (rst)
    regWrite.we && a == pin_ctrl_pkg::RPORT_GROUP0_DRIVE_OFS && !stopMode
    |=> s_q.rDrive[0] == $past(regWrite.data))
    else $error("group 0 drive lost");
  // the group 5 hole stores nothing
  map_hole_a: assert property (@(posedge clk) disable iff (rst)
    regWrite.we && a == 6'h35 && !stopMode |=> s_q.rDrive == $past(s_q.rDrive))
    else $error("hole write stored");
  // irq routing follows its register
  irq_map_a: assert property (@(posedge clk) disable iff (rst)
    !stopMode |=> funcSel.irqEnable == $past(s_q.irqSel))
    else $error("irq routing mismatch");
  // the fourth irq pin is released when routed
  irq_four_a: assert property (@(posedge clk) disable iff (rst)
    funcSel.irqEnable[3] |-> !padCtrl.rOe[3])
    else $error("irq four pin driven");
  // irq select write stores all four bits
  irq_write_a: assert property (@(posedge clk) disable iff (rst)
    regWrite.we && a == pin_ctrl_pkg::INTERRUPT_PIN_SELECT_OFS && !stopMode
    |=> s_q.irqSel == $past(regWrite.data))
    else $error("irq select lost");
  // event select keeps only bit 1
  event_write_a: assert property (@(posedge clk) disable iff (rst)
    regWrite.we && a == pin_ctrl_pkg::EVENT_PIN_SELECT_OFS && !stopMode
    |=> s_q.eventSel == $past(regWrite.data[1]))
    else $error("event select lost");
  // event input releases its pin
  event_pin_a: assert property (@(posedge clk) disable iff (rst)
    funcSel.eventEnable |-> !padCtrl.rOe[pin_ctrl_pkg::R4_0])
    else $error("event pin driven");
  // timer c output owns its pin direction
  timer_c_pin_a: assert property (@(posedge clk) disable iff (rst)
    s_q.timerCMode != pin_ctrl_pkg::TIMER_PORT_MODE && !stopMode
    |=> padCtrl.rOe[pin_ctrl_pkg::R3_1] == $past(timerCOutEn))
    else $error("timer c pin mismatch");
  // timer d output owns its pin direction
  timer_d_pin_a: assert property (@(posedge clk) disable iff (rst)
    s_q.timerDMode != pin_ctrl_pkg::TIMER_D_PORT_MODE && !stopMode
    |=> padCtrl.rOe[pin_ctrl_pkg::R3_2] == $past(timerDOutEn))
    else $error("timer d pin mismatch");
  // with the timer in port mode the drive bit rules
  timer_port_a: assert property (@(posedge clk) disable iff (rst)
    s_q.timerCMode == pin_ctrl_pkg::TIMER_PORT_MODE && !stopMode
    |=> padCtrl.rOe[pin_ctrl_pkg::R3_1] == $past(rDriveFlat[pin_ctrl_pkg::R3_1]))
    else $error("timer pin not port");
  // serial clock owns its pin direction
  serial_clk_pin_a: assert property (@(posedge clk) disable iff (rst)
    s_q.serialClk[pin_ctrl_pkg::SERIAL_CLK_PIN_BIT] && !stopMode
    |=> padCtrl.rOe[pin_ctrl_pkg::R4_1] == $past(serialClockOutEn))
    else $error("serial clock pin mismatch");
  // serial out drives the data bit
  serial_data_a: assert property (@(posedge clk) disable iff (rst)
    s_q.serialSel[pin_ctrl_pkg::SERIAL_OUT_SEL_BIT] && !stopMode
    |=> padCtrl.rOut[pin_ctrl_pkg::R4_3] == $past(serialOutData))
    else $error("serial data mismatch");
  // serial in releases its pin
  serial_in_pin_a: assert property (@(posedge clk) disable iff (rst)
    funcSel.serialInEnable |-> !padCtrl.rOe[pin_ctrl_pkg::R4_2])
    else $error("serial in pin driven");
  // serial pin select keeps two bits
  serial_sel_a: assert property (@(posedge clk) disable iff (rst)
    regWrite.we && a == pin_ctrl_pkg::SERIAL_PIN_SELECT_OFS && !stopMode
    |=> s_q.serialSel == $past(regWrite.data[1:0]))
    else $error("serial select lost");
  // clock source code passes through
  clock_source_a: assert property (@(posedge clk) disable iff (rst)
    !stopMode |=> funcSel.serialClockSource == $past(s_q.serialClk[2:0]))
    else $error("clock source mismatch");
  // open drain bit gates the pmos
  pmos_off_a: assert property (@(posedge clk) disable iff (rst)
    !stopMode |=> padCtrl.r43PmosOff == $past(s_q.misc[pin_ctrl_pkg::OPEN_DRAIN_BIT]))
    else $error("pmos gate mismatch");
  // comparator routing passes through
  comparator_a: assert property (@(posedge clk) disable iff (rst)
    !stopMode |=> funcSel.comparatorEnable == $past(s_q.cmpSel))
    else $error("comparator routing mismatch");
  // global pull bit off turns every pull off
  pull_gate_a: assert property (@(posedge clk) disable iff (rst)
    !pullOn && !stopMode |=> padCtrl.rPull == 38'h0 && padCtrl.dPull == 9'h0)
    else $error("pull on while gated");
  // r pins pull up from their own latch
  rport_pull_a: assert property (@(posedge clk) disable iff (rst)
    pullOn && !stopMode |=> padCtrl.rPull == $past(rLatchFlat))
    else $error("rport pull mismatch");
  // d0..d3 pull down on a zero latch
  dport_pulldown_a: assert property (@(posedge clk) disable iff (rst)
    pullOn && !stopMode |=> padCtrl.dPull[3:0] == ~$past(dportLatchIn[3:0]))
    else $error("dport pull-down mismatch");
  // upper d pins pull up on a one latch
  dport_pullup_a: assert property (@(posedge clk) disable iff (rst)
    pullOn && !stopMode |=> padCtrl.dPull[8:4] == $past(dportLatchIn[8:4]))
    else $error("dport pull-up mismatch");
  // d pins drive their latch value
  dport_out_a: assert property (@(posedge clk) disable iff (rst)
    !stopMode |=> padCtrl.dOut == $past(dportLatchIn))
    else $error("dport out mismatch");
  // misc register stores all four bits
  misc_write_a: assert property (@(posedge clk) disable iff (rst)
    regWrite.we && a == pin_ctrl_pkg::MISC_PIN_CONFIG_OFS && !stopMode
    |=> s_q.misc == $past(regWrite.data))
    else $error("misc write lost");
  // reset clears every output
  reset_clear_a: assert property (@(posedge clk)
    rst |=> padCtrl == '0 && funcSel == '0 && rportReadData == 4'h0)
    else $error("reset did not clear");
endmodule : port_pin_buffer_and_function_control
`default_nettype wire

/* test/pin_board_model.sv */
// pin model: resolves r port pad levels from drive, pull and floating state
`timescale 1ns/1ps
`default_nettype none
module pin_board_model (
  input wire logic clk,
  input wire pin_ctrl_pkg::pad_ctrl_t padCtrl,
  output logic [39:0] pinLevel
);
  logic flip_q = 1'b0;
  // floating pins toggle so a stale level never reads back as valid
  always @(posedge clk) begin
    flip_q <= ~flip_q;
  end
  // a driven pin follows its output, a pulled pin reads high
  always_comb begin
    pinLevel = {40{flip_q}};
    for (int i = 0; i < pin_ctrl_pkg::RPORT_PINS; i++) begin
      if (padCtrl.rOe[i]) begin
        pinLevel[i] = padCtrl.rOut[i];
      end else if (padCtrl.rPull[i]) begin
        pinLevel[i] = 1'b1;
      end
    end
  end
endmodule : pin_board_model
`default_nettype wire

/* test/tb.sv */
// testbench: register, latch and read sequences for the pin controller
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic stopMode = 1'b0;
  pin_ctrl_pkg::reg_write_t regWrite = '0;
  logic rportWrite = 1'b0;
  logic rportRead = 1'b0;
  logic [3:0] rportSlot = 4'h0;
  logic [3:0] rportData = 4'h0;
  logic [8:0] dportLatchIn = 9'h000;
  logic [6:0] periph = 7'h00;
  logic [39:0] pinLevel;
  logic [3:0] rportReadData;
  pin_ctrl_pkg::pad_ctrl_t padCtrl;
  pin_ctrl_pkg::func_sel_t funcSel;
  int failures = 0;
  int comparisons = 0;
  int cycles = 0;
  always #5 clk = ~clk;
  port_pin_buffer_and_function_control port_pin_buffer_and_function_control_i (
    .clk(clk), .rst(rst), .stopMode(stopMode), .regWrite(regWrite),
    .rportWrite(rportWrite), .rportSlot(rportSlot), .rportData(rportData),
    .rportRead(rportRead), .rportPinIn(pinLevel), .dportLatchIn(dportLatchIn),
    .timerCOut(periph[6]), .timerCOutEn(periph[5]), .timerDOut(periph[4]),
    .timerDOutEn(periph[3]), .serialClockOut(periph[2]), .serialClockOutEn(periph[1]),
    .serialOutData(periph[0]), .padCtrl(padCtrl), .funcSel(funcSel),
    .rportReadData(rportReadData));
  pin_board_model pin_board_model_i (.clk(clk), .padCtrl(padCtrl), .pinLevel(pinLevel));
  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // one write, then two spare edges so registered pad controls have settled
  task automatic wr(input logic [5:0] a, input logic [3:0] d);
    @(posedge clk);
    #1 regWrite = '{we: 1'b1, addr: a, data: d};
    @(posedge clk);
    #1 regWrite.we = 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask : wr
  // latch write or pin read on one group slot
  task automatic pio(input logic rd, input logic [3:0] s, input logic [3:0] d);
    @(posedge clk);
    #1 {rportRead, rportWrite, rportSlot, rportData} = {rd, ~rd, s, d};
    @(posedge clk);
    #1 {rportRead, rportWrite} = 2'b00;
    repeat (2) @(posedge clk);
    #1;
  endtask : pio
  task automatic close_out();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : close_out
  // guard against a hang well beyond the expected run length
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      $display("CHECK FAILED at %0t: run too long", $time);
      close_out();
    end
  end
  initial begin
    repeat (4) @(posedge clk);
    #1 rst = 1'b0;
    chk(40'(|{padCtrl, funcSel}), 40'h0);
    $display("test reset done");
    wr(6'h2c, 4'hf);
    chk(40'(padCtrl.dOe), 40'h00f);
    wr(6'h2d, 4'h3);
    wr(6'h2e, 4'h1);
    chk(40'(padCtrl.dOe), 40'h03f);
    wr(6'h2e, 4'he);
    chk(40'(padCtrl.dOe), 40'h1ff);
    wr(6'h30, 4'h5);
    wr(6'h3a, 4'hf);
    wr(6'h35, 4'hf);
    chk(40'(padCtrl.rOe), 40'h3000000005);
    $display("test buffer control done");
    wr(6'h31, 4'hf);
    pio(1'b0, 4'h1, 4'ha);
    chk(40'({padCtrl.rOut[7:4], padCtrl.rPull[7:4]}), 40'ha0);
    pio(1'b1, 4'h1, 4'h0);
    chk(40'(rportReadData), 40'ha);
    wr(6'h0c, 4'h8);
    dportLatchIn = 9'h1f0;
    repeat (3) @(posedge clk);
    #1;
    chk(40'({padCtrl.dPull, padCtrl.rPull[7:4]}), 40'h1ffa);
    dportLatchIn = 9'h00f;
    repeat (3) @(posedge clk);
    #1;
    chk(40'(padCtrl.dPull), 40'h0);
    chk(40'(padCtrl.dOut), 40'h00f);
    $display("test latch and pulls done");
    wr(6'h24, 4'hf);
    pio(1'b0, 4'h0, 4'h3);
    chk(40'({funcSel.irqEnable, padCtrl.rOe[3:0], padCtrl.rPull[3:0]}), 40'hf03);
    periph = 7'h61;
    wr(6'h04, 4'h3);
    for (int c = 0; c < 7; c++) begin
      wr(6'h05, {1'b1, 3'(c)});
      chk(40'(funcSel.serialClockSource), 40'(c));
    end
    chk(40'({funcSel.serialInEnable, funcSel.serialOutEnable, funcSel.serialClockEnable}), 40'h7);
    chk(40'({padCtrl.rOut[pin_ctrl_pkg::R4_3], padCtrl.rOe[pin_ctrl_pkg::R4_2]}), 40'h2);
    wr(6'h0c, 4'hc);
    chk(40'(padCtrl.r43PmosOff), 40'h1);
    $display("test serial done");
    wr(6'h25, 4'h2);
    wr(6'h14, 4'h1);
    wr(6'h15, 4'h1);
    wr(6'h18, 4'hf);
    chk(40'({funcSel.eventEnable, funcSel.timerCEnable, funcSel.timerDEnable}), 40'h7);
    chk(40'(funcSel.comparatorEnable), 40'h3);
    chk(40'({padCtrl.rOe[pin_ctrl_pkg::R3_1], padCtrl.rOut[pin_ctrl_pkg::R3_1]}), 40'h3);
    chk(40'({padCtrl.rOe[pin_ctrl_pkg::R3_2], padCtrl.rOut[pin_ctrl_pkg::R3_2]}), 40'h0);
    @(posedge clk);
    #1 stopMode = 1'b1;
    repeat (2) @(posedge clk);
    #1 stopMode = 1'b0;
    chk(40'(|{padCtrl.dOe, padCtrl.rOe, padCtrl.rPull, padCtrl.dPull, funcSel}), 40'h0);
    $display("test stop mode done");
    close_out();
  end
endmodule : tb
`default_nettype wire
